/* File: src/mtg_pkg.sv */
// package of constants and types for the march test generator
package mtg_pkg;
  // ---------------------------------------------------------------------------
  // counter layout
  // ---------------------------------------------------------------------------
  localparam int unsigned MTG_STAGES    = 4;
  localparam int unsigned MTG_STAGE_W   = 4;
  localparam int unsigned MTG_CNT_W     = MTG_STAGES * MTG_STAGE_W;
  localparam int unsigned MTG_ADDR_W    = 14;
  localparam int unsigned MTG_TOP_ADDR_BIT     = MTG_ADDR_W - 1;
  localparam int unsigned MTG_PATTERN_DATA_BIT = MTG_ADDR_W;
  localparam int unsigned MTG_SEQUENCE_END_BIT = MTG_ADDR_W + 1;
  localparam logic [MTG_CNT_W-1:0] MTG_CNT_RST = 16'h0000;
  typedef enum logic [1:0] {MTG_CLEAR, MTG_MARCH, MTG_DONE} mtg_state_t;
endpackage

/* File: src/mtg_cnt_if.sv */
// interface carrying the cascaded counter chain between generator and counters
interface mtg_cnt_if #(
  parameter int unsigned W = 16
);
  logic         en;
  logic [W-1:0] count;
  logic         carry;
  modport ctl (output en, input count, input carry);
  modport cnt (input en, output count, output carry);
endinterface

/* File: src/mtg_counter4.sv */
// one synchronous four-bit counter stage with enable and ripple carry
module mtg_counter4
  import mtg_pkg::*;
#(
  parameter int unsigned W = MTG_STAGE_W
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         en_i,
  output logic [W-1:0]      q_o,
  output logic              carry_o
);
  logic [W-1:0] q_q;
  logic [W-1:0] q_d;
  // next count: advance only when all lower stages carry
  always_comb begin
    q_d = en_i ? q_q + W'(1) : q_q;
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q_q <= '0;
    end else begin
      q_q <= q_d;
    end
  end
  assign q_o     = q_q;
  assign carry_o = en_i & (&q_q); // terminal count feeds the next stage
endmodule

/* File: src/mtg_top.sv */
// march test generator and checker for a one-bit-wide memory under test
module mtg_top
  import mtg_pkg::*;
#(
  parameter int unsigned ADDR_W = MTG_ADDR_W
) (
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  input  wire logic              rd_data_i,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic                   mem_we_o,
  output logic                   mem_wdata_o,
  output logic                   mem_re_o,
  output logic                   fail_o,
  output logic [ADDR_W-1:0]      fail_addr_o,
  output logic                   fail_sticky_o,
  output logic                   done_o
);
  // ---------------------------------------------------------------------------
  // counter chain
  // ---------------------------------------------------------------------------
  mtg_cnt_if #(.W(MTG_CNT_W)) cnt_bus ();
  logic [MTG_STAGES:0] carry_chain;
  assign carry_chain[0] = cnt_bus.en;
  // four stages advance as one wide binary counter
  for (genvar g = 0; g < MTG_STAGES; g++) begin : g_stage
    mtg_counter4 #(.W(MTG_STAGE_W)) u_stage (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .en_i    (carry_chain[g]),
      .q_o     (cnt_bus.count[g*MTG_STAGE_W +: MTG_STAGE_W]),
      .carry_o (carry_chain[g+1])
    );
  end
  assign cnt_bus.carry = carry_chain[MTG_STAGES];

  // ---------------------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------------------
  mtg_state_t  state_q;
  mtg_state_t  state_d;
  logic        phase_q; // low: read slot, high: write slot
  logic        phase_d;
  logic        pattern;
  logic        seq_end;
  logic [ADDR_W-1:0] addr;

  assign addr    = cnt_bus.count[ADDR_W-1:0];
  assign pattern = cnt_bus.count[MTG_PATTERN_DATA_BIT];
  // end once the end bit is set and the chain carries out of the top address bit;
  // the low stages' carry alone would stop pass two early, at a quarter of the range
  assign seq_end = cnt_bus.count[MTG_SEQUENCE_END_BIT] & carry_chain[MTG_STAGES-1] &
                   (&cnt_bus.count[MTG_PATTERN_DATA_BIT-1:MTG_CNT_W-MTG_STAGE_W]);

  // clearing steps every cycle, marching every second cycle
  always_comb begin
    state_d    = state_q;
    phase_d    = phase_q;
    cnt_bus.en = 1'b0;
    case (state_q)
      MTG_CLEAR: begin
        cnt_bus.en = 1'b1;
        if (&addr) begin
          state_d = MTG_MARCH;
        end
      end
      MTG_MARCH: begin
        phase_d    = ~phase_q;
        cnt_bus.en = phase_q;
        if (phase_q && seq_end) begin
          state_d = MTG_DONE;
        end
      end
      MTG_DONE: begin
        cnt_bus.en = 1'b0;
      end
      default: begin
        state_d = MTG_DONE;
      end
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= MTG_CLEAR;
      phase_q <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
    end
  end

  // ---------------------------------------------------------------------------
  // memory drive, registered
  // ---------------------------------------------------------------------------
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic we_q, we_d, re_q, re_d, wd_q, wd_d, exp_q, exp_d;
  // pattern is high in pass one and low in pass two: it is the write value
  always_comb begin
    addr_d = addr;
    we_d   = 1'b0;
    re_d   = 1'b0;
    wd_d   = 1'b0;
    exp_d  = exp_q;
    case (state_q)
      MTG_CLEAR: begin
        we_d = 1'b1;
        wd_d = 1'b0;
      end
      MTG_MARCH: begin
        re_d  = ~phase_q;
        we_d  = phase_q;
        wd_d  = pattern;
        exp_d = ~pattern;
      end
      default: begin
        addr_d = addr_q;
      end
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      addr_q <= '0;
      we_q   <= 1'b0;
      re_q   <= 1'b0;
      wd_q   <= 1'b0;
      exp_q  <= 1'b0;
    end else begin
      addr_q <= addr_d;
      we_q   <= we_d;
      re_q   <= re_d;
      wd_q   <= wd_d;
      exp_q  <= exp_d;
    end
  end
  assign mem_addr_o  = addr_q;
  assign mem_we_o    = we_q;
  assign mem_re_o    = re_q;
  assign mem_wdata_o = wd_q;

  // ---------------------------------------------------------------------------
  // checker: read data is sampled the cycle after the read strobe
  // ---------------------------------------------------------------------------
  logic              fail_q, fail_d, sticky_q, sticky_d, done_q, done_d;
  logic              chk_q, chk_d; // read answer due at this edge
  logic [ADDR_W-1:0] faddr_q, faddr_d;
  // the memory registers its answer, so the compare trails the strobe by one cycle;
  // address and expected value still hold the read's values in the write slot
  always_comb begin
    chk_d    = re_q;
    fail_d   = chk_q & (rd_data_i != exp_q);
    faddr_d  = chk_q ? addr_q : faddr_q;
    sticky_d = sticky_q | fail_d;
    done_d   = (state_q == MTG_DONE);
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      chk_q    <= 1'b0;
      fail_q   <= 1'b0;
      faddr_q  <= '0;
      sticky_q <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      chk_q    <= chk_d;
      fail_q   <= fail_d;
      faddr_q  <= faddr_d;
      sticky_q <= sticky_d;
      done_q   <= done_d;
    end
  end
  assign fail_o        = fail_q;
  assign fail_addr_o   = faddr_q;
  assign fail_sticky_o = sticky_q;
  assign done_o        = done_q;

  // ---------------------------------------------------------------------------
  // operation tally, held against the run length at the end
  // ---------------------------------------------------------------------------
  localparam int unsigned       OPS_W     = ADDR_W + 3;
  localparam logic [OPS_W-1:0] OPS_TOTAL = OPS_W'(5 * (2 ** ADDR_W));
  logic [OPS_W-1:0] ops_q;
  logic [OPS_W-1:0] ops_d;
  // every strobe counts once; a slot that issues nothing shows up as a short total
  always_comb begin
    ops_d = ops_q + OPS_W'(mem_we_o | mem_re_o);
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ops_q <= '0;
    end else begin
      ops_q <= ops_d;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  a_clear_writes_zero: assert property (@(posedge clk_i) disable iff (srst_i)
    $past(state_q == MTG_CLEAR) && !$past(srst_i) |-> mem_we_o && !mem_wdata_o)
    else $error("clearing did not write zero");
  a_read_then_write: assert property (@(posedge clk_i) disable iff (srst_i)
    mem_re_o |=> mem_we_o && (mem_addr_o == $past(mem_addr_o)))
    else $error("read not followed by write at same address");
  a_write_inverts_exp: assert property (@(posedge clk_i) disable iff (srst_i)
    mem_re_o |=> mem_wdata_o == !$past(exp_q))
    else $error("march write not inverse of expected");
  a_fail_on_mismatch: assert property (@(posedge clk_i) disable iff (srst_i)
    chk_q && (rd_data_i != exp_q) |=> fail_o && fail_addr_o == $past(addr_q))
    else $error("mismatch not flagged with address");
  a_total_ops: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(done_o) |-> ops_q == OPS_TOTAL)
    else $error("sequence length is not five operations per address");
  a_no_ops_when_done: assert property (@(posedge clk_i) disable iff (srst_i)
    done_o |-> !mem_we_o && !mem_re_o)
    else $error("memory operation after done");
  a_sticky_holds: assert property (@(posedge clk_i) disable iff (srst_i)
    fail_sticky_o |=> fail_sticky_o)
    else $error("sticky fail dropped");
  a_march_slot_len: assert property (@(posedge clk_i) disable iff (srst_i)
    state_q == MTG_MARCH && !phase_q |=> $stable(addr))
    else $error("march address held less than two steps");
  a_clear_advances: assert property (@(posedge clk_i) disable iff (srst_i)
    state_q == MTG_CLEAR && !(&addr) |=> addr == $past(addr) + 1'b1)
    else $error("clear pass did not step address");
endmodule

/* File: test/mtg_mem_model.sv */
// one-bit memory under test with a stuck-at-one and a stuck-at-zero cell
module mtg_mem_model
  import mtg_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic [MTG_ADDR_W-1:0] addr_i,
  input  wire logic                  we_i,
  input  wire logic                  wdata_i,
  input  wire logic                  re_i,
  input  wire logic [MTG_ADDR_W-1:0] sa1_addr_i,
  input  wire logic [MTG_ADDR_W-1:0] sa0_addr_i,
  output logic                       rd_data_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cells [2**MTG_ADDR_W];
  // answer one cycle after a read; toggle otherwise so a stale bit never passes
  always @(posedge clk_i) begin
    if (we_i) cells[addr_i] <= wdata_i;
    if (re_i) rd_data_o <= (addr_i == sa1_addr_i) ? 1'b1 :
                           (addr_i == sa0_addr_i) ? 1'b0 : cells[addr_i];
    else rd_data_o <= ~rd_data_o;
  end
endmodule

/* File: test/march_test_generator_test.sv */
// self-checking bench for the march test generator
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module march_test_generator_test;
  import mtg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 2**MTG_ADDR_W;
  logic                  clk_i = 1'b0;
  logic                  srst_i = 1'b1;
  logic                  rd_data, mem_we_o, mem_wdata_o, mem_re_o, fail_o, fail_sticky_o, done_o;
  logic [MTG_ADDR_W-1:0] mem_addr_o, fail_addr_o, sa1, sa0;
  logic [31:0]           seed = 32'h0771f4ab;
  logic                  last_re;
  int                    n_mismatch, total_checks, n_wr, n_rd, n_fail;
  // ---------------------------------------------------------------------------
  // expectations
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // stuck-one cell fails in pass one, stuck-zero cell in pass two
  function automatic logic [MTG_ADDR_W-1:0] exp_fail_addr(input int k);
    return (k == 0) ? sa1 : sa0;
  endfunction
  function automatic logic exp_wdata(input int reads);
    return (reads <= N) ? 1'b1 : 1'b0;
  endfunction
  always #4 clk_i = ~clk_i;
  mtg_top i_mtg_top (.clk_i(clk_i), .srst_i(srst_i), .rd_data_i(rd_data),
    .mem_addr_o(mem_addr_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
    .mem_re_o(mem_re_o), .fail_o(fail_o), .fail_addr_o(fail_addr_o),
    .fail_sticky_o(fail_sticky_o), .done_o(done_o));
  mtg_mem_model i_mtg_mem_model (.clk_i(clk_i), .addr_i(mem_addr_o), .we_i(mem_we_o),
    .wdata_i(mem_wdata_o), .re_i(mem_re_o), .sa1_addr_i(sa1), .sa0_addr_i(sa0),
    .rd_data_o(rd_data));
  // ---------------------------------------------------------------------------
  // monitor, sampled on the falling edge where outputs are settled
  // ---------------------------------------------------------------------------
  always @(negedge clk_i) begin
    if (srst_i) begin
      n_wr = 0;
      n_rd = 0;
      n_fail = 0;
      last_re = 1'b0;
    end else begin
      if (mem_we_o) begin
        if (n_wr < N) begin
          `CHK("clear addr", MTG_ADDR_W'(n_wr), mem_addr_o)
          `CHK("clear data", 1'b0, mem_wdata_o)
        end else begin
          `CHK("write after read", 1'b1, last_re)
          `CHK("write addr", MTG_ADDR_W'(n_rd - 1), mem_addr_o)
          `CHK("write data", exp_wdata(n_rd), mem_wdata_o)
        end
        n_wr++;
      end
      if (mem_re_o) begin
        `CHK("read addr", MTG_ADDR_W'(n_rd % N), mem_addr_o)
        n_rd++;
      end
      if (fail_o) begin
        `CHK("fail addr", exp_fail_addr(n_fail), fail_addr_o)
        n_fail++;
      end
      last_re = mem_re_o;
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog: one full sequence plus margin
  initial begin
    repeat (6 * N) @(posedge clk_i);
    n_mismatch++;
    conclude();
  end
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    seed = xorshift(seed);
    sa1 = MTG_ADDR_W'(seed % (N - 1));
    sa0 = MTG_ADDR_W'(N - 1); // corner: last cell
    repeat (5) @(posedge clk_i);
    #1 srst_i = 1'b0;
    repeat (40) @(posedge clk_i);
    #1 srst_i = 1'b1; // reset in mid-clear
    @(posedge clk_i);
    #1 `CHK("reset outputs", 4'h0, {mem_we_o, mem_re_o, done_o, fail_sticky_o})
    srst_i = 1'b0;
    $display("test reset done");
    for (int i = 0; i < 5 * N + 100 && done_o !== 1'b1; i++) @(negedge clk_i);
    #1 `CHK("done", 1'b1, done_o)
    `CHK("writes", 3 * N, n_wr)
    `CHK("reads", 2 * N, n_rd)
    `CHK("fails", 2, n_fail)
    `CHK("sticky", 1'b1, fail_sticky_o)
    repeat (20) @(posedge clk_i);
    #1 `CHK("quiet after end", 3'b001, {mem_we_o, mem_re_o, done_o})
    `CHK("no more writes", 3 * N, n_wr)
    $display("test march done");
    conclude();
  end
endmodule
